//--- fan_serial_ctrl.sv
// serial target port, working registers and nonvolatile word store of the fan driver
`timescale 1ns/1ps
module fan_serial_ctrl #(
  parameter int NVM_WORDS       = 32,
  parameter int NVM_BUSY_CYCLES = fan_serial_pkg::NVM_PROGRAM_CYCLES
) (
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          enable,
  input  wire logic                          speed_input_pin,
  input  wire logic                          tacho_output_pin_in,
  output logic                               tacho_output_pin_out,
  output logic                               tacho_output_pin_oe_b,
  input  wire logic                          tacho_pulse,
  input  wire logic                          strap_serial_b,
  input  wire fan_serial_pkg::motor_status_t status,
  output fan_serial_pkg::speed_control_t     control,
  output logic                               nvm_busy
);
  initial begin
    if (NVM_WORDS != 32) $error("nonvolatile store must hold 32 words");
    if (NVM_BUSY_CYCLES < 1) $error("programming time must be at least one cycle");
  end

  // two-flop synchronisers; the first stage feeds only the second
  // edge history resets to the released level, so a strapped-low line only shows a fall in idle
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_prev;
  logic       sda_prev;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else if (enable) begin
      scl_sync <= {scl_sync[0], speed_input_pin};
      sda_sync <= {sda_sync[0], tacho_output_pin_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  assign scl        = scl_sync[1];
  assign sda        = sda_sync[1];
  assign scl_rise   = scl && !scl_prev;
  assign scl_fall   = !scl && scl_prev;
  assign start_seen = scl && scl_prev && sda_prev && !sda;
  assign stop_seen  = scl && scl_prev && !sda_prev && sda;

  typedef enum logic [2:0] {
    IDLE, ADDRESS, ADDR_ACK, INDEX, WR_DATA, DATA_ACK, RD_DATA, RD_ACK
  } link_state_t;

  link_state_t state;
  logic [7:0]  shift;
  logic [3:0]  bit_count;
  logic        byte_count;
  logic        read_dir;
  logic        matched;
  logic [7:0]  register_index;
  logic [15:0] write_word;
  logic [15:0] read_word;
  logic        ack_pending;
  logic        write_strobe;
  logic        any_command;
  logic        index_done;
  logic        word_done;

  // bit engine: sample on scl rise, change drive on scl fall
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state          <= IDLE;
      shift          <= 8'h00;
      bit_count      <= 4'h0;
      byte_count     <= 1'b0;
      read_dir       <= 1'b0;
      matched        <= 1'b0;
      register_index <= 8'h00;
      write_word     <= 16'h0000;
      write_strobe   <= 1'b0;
      any_command    <= 1'b0;
      ack_pending    <= 1'b0;
    end else if (enable) begin
      write_strobe <= 1'b0;
      if (start_seen) begin
        state     <= ADDRESS;
        bit_count <= 4'h0;
        matched   <= 1'b0;
      end else if (stop_seen) begin
        state <= IDLE;
      end else begin
        case (state)
          IDLE: begin
          end
          ADDRESS, INDEX, WR_DATA: begin
            if (scl_rise) begin
              shift     <= {shift[6:0], sda};
              bit_count <= bit_count + 4'h1;
            end else if (scl_fall && bit_count == 4'h8) begin
              bit_count <= 4'h0;
              if (state == ADDRESS) begin
                if (shift[7:1] == fan_serial_pkg::TARGET_ADDR) begin
                  matched     <= 1'b1;
                  read_dir    <= shift[0];
                  any_command <= 1'b1;
                  byte_count  <= 1'b0;
                  state       <= ADDR_ACK;
                end else begin
                  state <= IDLE;
                end
              end else if (state == INDEX) begin
                register_index <= shift;
                state          <= DATA_ACK;
              end else begin
                // a third data byte is acked and dropped
                if (!byte_count) write_word[15:8] <= shift;
                else if (!word_done) write_word[7:0] <= shift;
                if (byte_count && !word_done) write_strobe <= 1'b1;
                state <= DATA_ACK;
              end
            end
          end
          ADDR_ACK: begin
            if (scl_fall) begin
              state <= read_dir ? RD_DATA : INDEX;
            end
          end
          DATA_ACK: begin
            if (scl_fall) begin
              // once the first data byte is in, the next data byte fills the low half
              if (index_done) byte_count <= 1'b1;
              state <= WR_DATA;
            end
          end
          RD_DATA: begin
            if (scl_rise) bit_count <= bit_count + 4'h1;
            else if (scl_fall && bit_count == 4'h8) begin
              bit_count <= 4'h0;
              state     <= RD_ACK;
            end
          end
          RD_ACK: begin
            if (scl_rise) ack_pending <= !sda;
            else if (scl_fall) begin
              byte_count <= 1'b1;
              state      <= ack_pending && !byte_count ? RD_DATA : IDLE;
            end
          end
          default: state <= IDLE;
        endcase
      end
    end
  end

  // byte counter for writes: first data byte goes high, second low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      index_done <= 1'b0;
      word_done  <= 1'b0;
    end else if (enable) begin
      if (start_seen || stop_seen) begin
        index_done <= 1'b0;
        word_done  <= 1'b0;
      end else begin
        if (state == DATA_ACK && scl_fall) index_done <= 1'b1;
        if (write_strobe) word_done <= 1'b1;
      end
    end
  end

  // registers
  logic [15:0] param_regs [0:31];
  logic [15:0] nvm_mem [0:31];
  logic [15:0] start_fail;
  logic [15:0] start_try;
  logic [fan_serial_pkg::LOCK_CAUSE_BITS-1:0] lock_causes;
  logic [3:0]  nvm_control;
  logic [4:0]  nvm_word_index;
  logic [15:0] nvm_new_word;
  logic [15:0] nvm_stored_word;
  logic [fan_serial_pkg::DUTY_BITS-1:0] speed_demand;
  logic        demand_written;
  logic        wr_hit;
  assign wr_hit = write_strobe && index_done;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      nvm_control    <= 4'h0;
      nvm_word_index <= 5'h00;
      nvm_new_word   <= 16'h0000;
      speed_demand   <= 9'h000;
      demand_written <= 1'b0;
    end else if (enable && wr_hit) begin
      case (register_index)
        fan_serial_pkg::REG_NVM_CONTROL: nvm_control <= write_word[3:0];
        fan_serial_pkg::REG_NVM_SELECT:  nvm_word_index <= write_word[4:0];
        fan_serial_pkg::REG_NVM_WRITE:   nvm_new_word <= write_word;
        fan_serial_pkg::REG_SPEED_DEMAND: begin
          speed_demand   <= write_word[8:0];
          demand_written <= 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // working parameter mirror: index minus 64 selects the word
  logic [7:0] mirror_slot;
  assign mirror_slot = register_index - 8'(fan_serial_pkg::PARAM_MIRROR_BASE);
  always_ff @(posedge clock) begin
    if (enable && wr_hit && register_index >= fan_serial_pkg::PARAM_FIRST
        && register_index <= fan_serial_pkg::PARAM_LAST)
      param_regs[mirror_slot[4:0]] <= write_word;
  end

  // counters count events; a zero write clears, and an event in that cycle still counts
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      start_fail  <= 16'h0000;
      start_try   <= 16'h0000;
      lock_causes <= '0;
    end else if (enable) begin
      if (wr_hit && register_index == fan_serial_pkg::REG_START_FAIL && write_word == 16'h0000)
        start_fail <= {15'h0000, status.startup_failure};
      else if (status.startup_failure) start_fail <= start_fail + 16'h0001;
      if (wr_hit && register_index == fan_serial_pkg::REG_START_TRY && write_word == 16'h0000)
        start_try <= {15'h0000, status.startup_attempt};
      else if (status.startup_attempt) start_try <= start_try + 16'h0001;
      if (wr_hit && register_index == fan_serial_pkg::REG_LOCK_CAUSES
          && write_word[fan_serial_pkg::LOCK_CLEAR_BIT])
        lock_causes <= status.lock_events;
      else lock_causes <= lock_causes | status.lock_events;
    end
  end

  // nonvolatile sequencer: erase or write busy for the programming time
  // the time is counted in core clocks, so a slower clock needs a smaller count
  logic [31:0] busy_count;
  logic        op_go;
  assign op_go = wr_hit && register_index == fan_serial_pkg::REG_NVM_CONTROL
                 && write_word[fan_serial_pkg::CTL_VOLTAGE_BIT];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_count <= 32'h0;
      nvm_busy   <= 1'b0;
    end else if (enable) begin
      if (op_go && !nvm_busy && (write_word[fan_serial_pkg::CTL_ERASE_BIT]
          || write_word[fan_serial_pkg::CTL_WRITE_BIT])) begin
        busy_count <= 32'(NVM_BUSY_CYCLES - 1);
        nvm_busy   <= 1'b1;
      end else if (busy_count != 32'h0) busy_count <= busy_count - 32'h1;
      else nvm_busy <= 1'b0;
    end
  end

  // store change happens at launch; the busy time only blocks the next one
  always_ff @(posedge clock) begin
    if (enable && op_go && !nvm_busy) begin
      if (write_word[fan_serial_pkg::CTL_ERASE_BIT])
        nvm_mem[nvm_word_index] <= fan_serial_pkg::NVM_ERASED_WORD;
      else if (write_word[fan_serial_pkg::CTL_WRITE_BIT])
        nvm_mem[nvm_word_index] <= nvm_mem[nvm_word_index] | nvm_new_word;
    end
  end
  assign nvm_stored_word = nvm_mem[nvm_word_index];

  // read data mux
  logic [15:0] next_read_word;
  always_comb begin
    next_read_word = fan_serial_pkg::REG_RESET;
    case (register_index)
      fan_serial_pkg::REG_APPLIED_DUTY: next_read_word = {7'h00, status.applied_duty};
      fan_serial_pkg::REG_DIE_TEMP:     next_read_word = {8'h00, status.die_temperature};
      fan_serial_pkg::REG_START_FAIL:   next_read_word = start_fail;
      fan_serial_pkg::REG_START_TRY:    next_read_word = start_try;
      fan_serial_pkg::REG_FAULT_FLAGS:  next_read_word = {6'h00, status.fault_flags};
      fan_serial_pkg::REG_LOCK_CAUSES:  next_read_word = {9'h000, lock_causes};
      fan_serial_pkg::REG_NVM_CONTROL:  next_read_word = {12'h000, nvm_control};
      fan_serial_pkg::REG_NVM_SELECT:   next_read_word = {11'h000, nvm_word_index};
      fan_serial_pkg::REG_NVM_WRITE:    next_read_word = nvm_new_word;
      fan_serial_pkg::REG_NVM_READ:     next_read_word = nvm_stored_word;
      fan_serial_pkg::REG_SPEED_DEMAND: next_read_word = {7'h00, speed_demand};
      default: begin
        if (register_index >= fan_serial_pkg::PARAM_FIRST
            && register_index <= fan_serial_pkg::PARAM_LAST)
          next_read_word = param_regs[mirror_slot[4:0]];
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) read_word <= 16'h0000;
    else if (enable && state == ADDR_ACK && scl_fall && read_dir)
      read_word <= next_read_word;
    // the eighth fall also shifts, so the low byte's first bit is ready after the ack
    else if (enable && state == RD_DATA && scl_fall)
      read_word <= {read_word[14:0], 1'b0};
  end

  // pin drive: open-drain during transfer, tacho only while idle before the first command, released otherwise
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tacho_output_pin_out  <= 1'b1;
      tacho_output_pin_oe_b <= 1'b1;
    end else if (enable) begin
      // never driven high: the line is only pulled, so a clash with the host cannot short it
      tacho_output_pin_out <= 1'b0;
      if (state == IDLE && !any_command)
        tacho_output_pin_oe_b <= tacho_pulse;  // open-drain tacho when link unused
      else if (state == ADDR_ACK || (state == DATA_ACK && !read_dir))
        tacho_output_pin_oe_b <= 1'b0;
      else if (state == RD_DATA)
        tacho_output_pin_oe_b <= read_word[15];
      else
        tacho_output_pin_oe_b <= 1'b1;
    end
  end

  // speed demand path; the strap pin is synchronised and caught once it has settled
  logic [1:0] strap_sync;
  logic [1:0] strap_age;
  logic       strap_seen;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strap_sync <= 2'h3;
      strap_age  <= 2'h0;
      strap_seen <= 1'b0;
      control    <= '0;
    end else if (enable) begin
      strap_sync <= {strap_sync[0], strap_serial_b};
      if (strap_age != 2'h3) strap_age <= strap_age + 2'h1;
      if (strap_age == 2'h2) strap_seen <= !strap_sync[1];
      control.serial_active <= any_command;
      control.serial_mode   <= demand_written;
      // duty equals code over 511; zero until 165 written once commands seen
      control.speed_demand  <= any_command ? speed_demand : 9'h000;
    end
  end
endmodule : fan_serial_ctrl

//--- fan_serial_pkg.sv
// shared constants and types for the fan driver serial control port
package fan_serial_pkg;
  localparam logic [6:0]  TARGET_ADDR        = 7'h55;
  localparam int          PARAM_MIRROR_BASE  = 64;
  localparam logic [7:0]  PARAM_FIRST        = 8'h48;
  localparam logic [7:0]  PARAM_LAST         = 8'h5E;
  localparam logic [7:0]  REG_APPLIED_DUTY   = 8'h80;
  localparam logic [7:0]  REG_DIE_TEMP       = 8'h8A;
  localparam logic [7:0]  REG_START_FAIL     = 8'h90;
  localparam logic [7:0]  REG_START_TRY      = 8'h91;
  localparam logic [7:0]  REG_FAULT_FLAGS    = 8'h93;
  localparam logic [7:0]  REG_LOCK_CAUSES    = 8'h94;
  localparam logic [7:0]  REG_NVM_CONTROL    = 8'hA1;
  localparam logic [7:0]  REG_NVM_SELECT     = 8'hA2;
  localparam logic [7:0]  REG_NVM_WRITE      = 8'hA3;
  localparam logic [7:0]  REG_NVM_READ       = 8'hA4;
  localparam logic [7:0]  REG_SPEED_DEMAND   = 8'hA5;
  localparam int          CTL_VOLTAGE_BIT    = 0;
  localparam int          CTL_ERASE_BIT      = 1;
  localparam int          CTL_WRITE_BIT      = 2;
  localparam int          CTL_READ_BIT       = 3;
  localparam int          LOCK_CLEAR_BIT     = 15;
  localparam int          LOCK_CAUSE_BITS    = 7;
  localparam int          FAULT_BITS         = 10;
  localparam int          DUTY_BITS          = 9;
  localparam logic [15:0] NVM_ERASED_WORD    = 16'h0000;
  localparam logic [15:0] REG_RESET          = 16'h0000;
  localparam int          CLOCK_MHZ          = 200;
  localparam int          NVM_PROGRAM_MS     = 12;
  localparam int          NVM_PROGRAM_CYCLES = NVM_PROGRAM_MS * CLOCK_MHZ * 1000;

  typedef struct packed {
    logic [DUTY_BITS-1:0]       applied_duty;
    logic [7:0]                 die_temperature;
    logic [FAULT_BITS-1:0]      fault_flags;
    logic [LOCK_CAUSE_BITS-1:0] lock_events;
    logic                       startup_attempt;
    logic                       startup_failure;
  } motor_status_t;

  typedef struct packed {
    logic                 serial_mode;
    logic                 serial_active;
    logic [DUTY_BITS-1:0] speed_demand;
  } speed_control_t;
endpackage : fan_serial_pkg

//--- fan_serial_ctrl_asserts.sv
// concurrent checks on the ports of the fan driver serial control port
`timescale 1ns/1ps
module fan_serial_ctrl_asserts #(
  parameter int NVM_WORDS       = 32,
  parameter int NVM_BUSY_CYCLES = 50
) (
  input wire logic                           clock,
  input wire logic                           rst_b,
  input wire logic                           enable,
  input wire logic                           speed_input_pin,
  input wire logic                           tacho_output_pin_in,
  input wire logic                           tacho_output_pin_out,
  input wire logic                           tacho_output_pin_oe_b,
  input wire logic                           tacho_pulse,
  input wire logic                           strap_serial_b,
  input wire fan_serial_pkg::motor_status_t  status,
  input wire fan_serial_pkg::speed_control_t control,
  input wire logic                           nvm_busy
);
  // run length of the busy level; a repetition would be far too long to unroll
  int busy_run;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      busy_run <= 0;
    end else if (enable) begin
      busy_run <= nvm_busy ? busy_run + 1 : 0;
    end
  end
  default clocking dc @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  open_drain_out_a: assert property ($past(rst_b) && $past(enable) |-> !tacho_output_pin_out)
    else $error("tacho line driven high");
  oe_scl_low_a: assert property (
    control.serial_active && $changed(tacho_output_pin_oe_b) |-> !speed_input_pin)
    else $error("data line changed while clock high");
  pin_mode_a: assert property (
    !control.serial_active |-> !control.serial_mode && control.speed_demand == 9'h000)
    else $error("serial demand before any command");
  active_hold_a: assert property ($past(control.serial_active) |-> control.serial_active)
    else $error("serial mode left without reset");
  mode_needs_cmd_a: assert property (control.serial_mode |-> control.serial_active)
    else $error("demand register live without command");
  demand_write_a: assert property ($changed(control.speed_demand) |-> ##[0:1] control.serial_mode)
    else $error("demand changed without demand write");
  busy_len_a: assert property ($fell(nvm_busy) |-> busy_run == NVM_BUSY_CYCLES)
    else $error("programming busy of wrong length");
  busy_max_a: assert property (busy_run <= NVM_BUSY_CYCLES)
    else $error("programming busy too long");
  busy_needs_cmd_a: assert property (nvm_busy |-> control.serial_active)
    else $error("programming started without command");
endmodule : fan_serial_ctrl_asserts

//--- fan_host_model.sv
// i2c host model: drives the speed pin as scl and pulls the tacho line as sda
`timescale 1ns/1ps
module fan_host_model (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  localparam int QUARTER = 8;
  // both pins held low through power-up so the pin demand stays at zero
  initial begin
    scl     = 1'b0;
    sda_low = 1'b1;
  end
  task automatic put(input logic c, input logic d);
    @(posedge clock);
    scl     <= c;
    sda_low <= !d;
    repeat (QUARTER - 1) @(posedge clock);
  endtask : put
  task automatic idle;
    put(1'b0, 1'b1);
    put(1'b1, 1'b1);
  endtask : idle
  // data changes only while scl is low, sampled mid high phase
  task automatic bit_io(input logic b, output logic seen);
    put(1'b0, b);
    put(1'b1, b);
    seen = sda;
    put(1'b1, b);
    put(1'b0, b);
  endtask : bit_io
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                         output logic ninth);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(last, ninth);
  endtask : byte_io
  task automatic start;
    put(1'b1, 1'b1);
    put(1'b1, 1'b0);
    put(1'b0, 1'b0);
  endtask : start
  task automatic stop;
    put(1'b0, 1'b0);
    put(1'b1, 1'b0);
    put(1'b1, 1'b1);
  endtask : stop
  // address with write bit, index, high byte, low byte
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [15:0] data, output logic acked);
    logic [7:0] rx;
    logic [3:0] n;
    start();
    byte_io({addr, 1'b0}, 1'b1, rx, n[0]);
    byte_io(idx, 1'b1, rx, n[1]);
    byte_io(data[15:8], 1'b1, rx, n[2]);
    byte_io(data[7:0], 1'b1, rx, n[3]);
    stop();
    acked = (n === 4'h0);
  endtask : write_reg
  // index set, stop, restart with read bit; high byte acked, low byte not
  task automatic read_reg(input logic [6:0] addr, input logic [7:0] idx,
                          output logic [15:0] data, output logic acked);
    logic [7:0] rx;
    logic [3:0] n;
    start();
    byte_io({addr, 1'b0}, 1'b1, rx, n[0]);
    byte_io(idx, 1'b1, rx, n[1]);
    stop();
    start();
    byte_io({addr, 1'b1}, 1'b1, rx, n[2]);
    byte_io(8'hFF, 1'b0, data[15:8], n[3]);
    byte_io(8'hFF, 1'b1, data[7:0], n[3]);
    stop();
    acked = (n[2:0] === 3'h0);
  endtask : read_reg
endmodule : fan_host_model

//--- fan_serial_ctrl_bench.sv
// self-checking bench for the fan driver serial control port
`timescale 1ns/1ps
module fan_serial_ctrl_bench;
  localparam int BUSY = 4000;
  logic                           clock;
  logic                           rst_b;
  logic                           enable;
  logic                           tacho_pulse;
  logic                           strap_serial_b;
  fan_serial_pkg::motor_status_t  status;
  fan_serial_pkg::speed_control_t control;
  logic                           nvm_busy;
  logic                           scl;
  logic                           host_low;
  logic                           pin_out;
  logic                           pin_oe_b;
  wire                            sda;
  int                             err_total;
  int                             check_count;
  logic [15:0]                    v;
  logic                           ok;
  // pulled-up line, low when either side pulls
  assign sda = !(host_low || (!pin_oe_b && !pin_out));
  fan_serial_ctrl #(.NVM_WORDS(32), .NVM_BUSY_CYCLES(BUSY)) dut (
    .clock(clock), .rst_b(rst_b), .enable(enable), .speed_input_pin(scl),
    .tacho_output_pin_in(sda), .tacho_output_pin_out(pin_out),
    .tacho_output_pin_oe_b(pin_oe_b), .tacho_pulse(tacho_pulse),
    .strap_serial_b(strap_serial_b), .status(status), .control(control),
    .nvm_busy(nvm_busy));
  fan_host_model host (.clock(clock), .sda(sda), .scl(scl), .sda_low(host_low));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    check_count++;
    if (seen !== want) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic wr(input logic [7:0] idx, input logic [15:0] d);
    host.write_reg(fan_serial_pkg::TARGET_ADDR, idx, d, ok);
    check({15'h0000, ok}, 16'h0001);
  endtask : wr
  task automatic expect_reg(input logic [7:0] idx, input logic [15:0] want);
    host.read_reg(fan_serial_pkg::TARGET_ADDR, idx, v, ok);
    check(v, want);
  endtask : expect_reg
  task automatic wait_idle;
    for (int n = 0; n < BUSY + 100 && nvm_busy !== 1'b0; n++) @(posedge clock);
    check({15'h0000, nvm_busy}, 16'h0000);
  endtask : wait_idle
  task automatic t_pin_mode;
    check(16'(control), 16'h0000);
    check({15'h0000, pin_out}, 16'h0000);
    tacho_pulse <= 1'b0;
    repeat (6) @(posedge clock);
    check({15'h0000, pin_oe_b}, 16'h0000);
    tacho_pulse <= 1'b1;
    enable      <= 1'b0;
    repeat (20) @(posedge clock);
    enable <= 1'b1;
    repeat (6) @(posedge clock);
    check({15'h0000, pin_oe_b}, 16'h0001);
  endtask : t_pin_mode
  task automatic t_wrong_addr;
    host.write_reg(7'h2A, fan_serial_pkg::REG_SPEED_DEMAND, 16'h01FF, ok);
    check({15'h0000, ok}, 16'h0000);
    check(16'(control), 16'h0000);
  endtask : t_wrong_addr
  task automatic t_demand;
    wr(fan_serial_pkg::REG_SPEED_DEMAND, 16'h01FF);
    check(16'(control), 16'h07FF);
    expect_reg(fan_serial_pkg::REG_SPEED_DEMAND, 16'h01FF);
    wr(fan_serial_pkg::REG_SPEED_DEMAND, 16'h0066);
    check(16'(control.speed_demand), 16'h0066);
  endtask : t_demand
  task automatic t_status;
    status.applied_duty    <= 9'h123;
    status.die_temperature <= 8'h85;
    status.fault_flags     <= 10'h2A5;
    repeat (4) @(posedge clock);
    host.write_reg(fan_serial_pkg::TARGET_ADDR, fan_serial_pkg::REG_APPLIED_DUTY, 16'h0000, ok);
    expect_reg(fan_serial_pkg::REG_APPLIED_DUTY, 16'h0123);
    expect_reg(fan_serial_pkg::REG_DIE_TEMP, 16'h0085);
    expect_reg(fan_serial_pkg::REG_FAULT_FLAGS, 16'h02A5);
    expect_reg(8'h20, 16'h0000);
  endtask : t_status
  task automatic t_counters;
    for (int i = 0; i < 3; i++) begin
      status.startup_attempt <= 1'b1;
      status.startup_failure <= (i < 2);
      @(posedge clock);
      status.startup_attempt <= 1'b0;
      status.startup_failure <= 1'b0;
      @(posedge clock);
    end
    expect_reg(fan_serial_pkg::REG_START_TRY, 16'h0003);
    expect_reg(fan_serial_pkg::REG_START_FAIL, 16'h0002);
    wr(fan_serial_pkg::REG_START_TRY, 16'h0000);
    expect_reg(fan_serial_pkg::REG_START_TRY, 16'h0000);
    expect_reg(fan_serial_pkg::REG_START_FAIL, 16'h0002);
  endtask : t_counters
  task automatic t_lock;
    status.lock_events <= 7'h45;
    @(posedge clock);
    status.lock_events <= 7'h00;
    expect_reg(fan_serial_pkg::REG_LOCK_CAUSES, 16'h0045);
    wr(fan_serial_pkg::REG_LOCK_CAUSES, 16'h8000);
    expect_reg(fan_serial_pkg::REG_LOCK_CAUSES, 16'h0000);
  endtask : t_lock
  task automatic t_params;
    wr(8'h48, 16'h48C3);
    wr(8'h5E, 16'h1234);
    expect_reg(8'h48, 16'h48C3);
    expect_reg(8'h5E, 16'h1234);
  endtask : t_params
  // erase or program one word, then check that the busy flag is up
  task automatic nvm_op(input logic [15:0] idx, input logic [15:0] d, input logic [15:0] c);
    wr(fan_serial_pkg::REG_NVM_SELECT, idx);
    wr(fan_serial_pkg::REG_NVM_WRITE, d);
    wr(fan_serial_pkg::REG_NVM_CONTROL, c);
    check({15'h0000, nvm_busy}, 16'h0001);
  endtask : nvm_op
  task automatic t_nvm;
    nvm_op(16'h0005, 16'h0000, 16'h0003);
    wait_idle();
    nvm_op(16'h0005, 16'h0105, 16'h0005);
    wait_idle();
    wr(fan_serial_pkg::REG_NVM_CONTROL, 16'h0008);
    expect_reg(fan_serial_pkg::REG_NVM_READ, 16'h0105);
    // top word: a program issued while still busy must be dropped
    nvm_op(16'h001F, 16'h0000, 16'h0003);
    wr(fan_serial_pkg::REG_NVM_WRITE, 16'hFFFF);
    wr(fan_serial_pkg::REG_NVM_CONTROL, 16'h0005);
    check({15'h0000, nvm_busy}, 16'h0001);
    wait_idle();
    wr(fan_serial_pkg::REG_NVM_CONTROL, 16'h0008);
    expect_reg(fan_serial_pkg::REG_NVM_READ, 16'h0000);
  endtask : t_nvm
  initial begin
    rst_b          = 1'b0;
    enable         = 1'b1;
    tacho_pulse    = 1'b1;
    strap_serial_b = 1'b0;
    status         = '0;
    err_total      = 0;
    check_count    = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    t_pin_mode();
    host.idle();
    t_wrong_addr();
    t_demand();
    t_status();
    t_counters();
    t_lock();
    t_params();
    t_nvm();
    give_verdict();
  end
  // traffic takes about 60000 cycles; a hang ends the run as a mismatch
  initial begin
    repeat (90000) @(posedge clock);
    err_total++;
    give_verdict();
  end
endmodule : fan_serial_ctrl_bench
bind fan_serial_ctrl fan_serial_ctrl_asserts #(
  .NVM_WORDS(NVM_WORDS), .NVM_BUSY_CYCLES(NVM_BUSY_CYCLES)
) checks (
  .clock(clock), .rst_b(rst_b), .enable(enable), .speed_input_pin(speed_input_pin),
  .tacho_output_pin_in(tacho_output_pin_in), .tacho_output_pin_out(tacho_output_pin_out),
  .tacho_output_pin_oe_b(tacho_output_pin_oe_b), .tacho_pulse(tacho_pulse),
  .strap_serial_b(strap_serial_b), .status(status), .control(control), .nvm_busy(nvm_busy));
